// >>> common/srs_pkg.sv
// constants and types of the solenoid reference shaper
package srs_pkg;
	localparam int          DATA_W        = 16;
	localparam int          CLK_PERIOD_NS = 5;
	localparam int          RAMP_TICK_NS  = 1000;
	localparam int          RAMP_TICK_CYC = RAMP_TICK_NS / CLK_PERIOD_NS;
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_SCALE_POS = 8'h04;
	localparam logic [7:0]  OFS_SCALE_NEG = 8'h08;
	localparam logic [7:0]  OFS_BIAS_POS  = 8'h0C;
	localparam logic [7:0]  OFS_BIAS_NEG  = 8'h10;
	localparam logic [7:0]  OFS_THRESHOLD = 8'h14;
	localparam logic [7:0]  OFS_OFFSET    = 8'h18;
	localparam logic [7:0]  OFS_RATE01    = 8'h1C;
	localparam logic [7:0]  OFS_RATE23    = 8'h20;
	localparam logic [7:0]  OFS_LIN       = 8'h24;
	localparam logic [7:0]  OFS_DITHER    = 8'h28;
	localparam logic [7:0]  OFS_DITH_AMP  = 8'h2C;
	localparam logic [7:0]  OFS_PCAP      = 8'h30;
	localparam logic [7:0]  OFS_STATUS    = 8'h34;
	localparam int          CTRL_SRC_BIT  = 0;
	localparam int          CTRL_RAMP_BIT = 1;
	localparam int          CTRL_MODE_LSB = 2;
	localparam int          CTRL_PLIM_BIT = 4;
	localparam int          CTRL_W        = 5;
	localparam int          STAT_LIM_BIT  = 16;
	localparam int          STAT_EN_BIT   = 17;
	localparam int          LIN_FRAC      = 8;
	localparam int          SCALE_FRAC    = 15;
	localparam logic [4:0]  RST_CTRL      = 5'h00;
	localparam logic [15:0] RST_SCALE     = 16'h7FFF;
	localparam logic [15:0] RST_ZERO16    = 16'h0000;
	localparam logic [15:0] RST_RATE      = 16'h0040;
	localparam logic [15:0] RST_LIN_KNEE  = 16'h7FFF;
	localparam logic [15:0] RST_LIN_GAIN  = 16'h0100;
	localparam logic [15:0] RST_DITH_BASE = 16'h0100;
	localparam logic [15:0] RST_DITH_SLP  = 16'h0100;
	localparam logic [31:0] RST_PCAP      = 32'hFFFFFFFF;
	typedef enum logic [1:0] {
		SRS_RAMP_SINGLE = 2'b00,
		SRS_RAMP_UPDOWN = 2'b01,
		SRS_RAMP_QUAD   = 2'b10
	} srs_ramp_mode_t;
	typedef enum logic {
		SRS_DIV_IDLE = 1'b0,
		SRS_DIV_RUN  = 1'b1
	} srs_div_state_t;
endpackage

// >>> hdl/srs_divider.sv
// iterative restoring divider for the power limiter
`timescale 1ns/1ps
module srs_divider
#(
	parameter int NUM_W = 32,
	parameter int DEN_W = 16
)
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// operands, taken when start is seen in idle
	input  wire logic             start,
	input  wire logic [NUM_W-1:0] numerator,
	input  wire logic [DEN_W-1:0] denominator,
	// result, held until the next division ends; done pulses for one cycle only
	output logic                  done,
	output logic      [NUM_W-1:0] quotient
);
	import srs_pkg::*;
	localparam int CNT_W = $clog2(NUM_W + 1);
	initial
	begin
		if (NUM_W < 2 || DEN_W < 2)
			$error("srs_divider: operand widths too small");
	end
	typedef struct packed {
		srs_div_state_t   state;
		logic [CNT_W-1:0] cnt;
		logic [DEN_W:0]   rem;
		logic [NUM_W-1:0] quo;
		logic [DEN_W-1:0] den;
		logic             done;
		logic [NUM_W-1:0] result;
	} srs_div_t;
	srs_div_t s_reg;
	srs_div_t s_next;
	logic [DEN_W:0] shifted;
	always_comb
	begin
		s_next = s_reg;
		s_next.done = 1'b0;
		shifted = {s_reg.rem[DEN_W-1:0], s_reg.quo[NUM_W-1]};
		case (s_reg.state)
			SRS_DIV_IDLE:
				if (start)
				begin
					s_next.state = SRS_DIV_RUN;
					s_next.cnt = CNT_W'(NUM_W);
					s_next.rem = '0;
					s_next.quo = numerator;
					s_next.den = denominator;
				end
			SRS_DIV_RUN:
			begin
				if (shifted >= {1'b0, s_reg.den})
				begin
					s_next.rem = shifted - {1'b0, s_reg.den};
					s_next.quo = {s_reg.quo[NUM_W-2:0], 1'b1};
				end
				else
				begin
					s_next.rem = shifted;
					s_next.quo = {s_reg.quo[NUM_W-2:0], 1'b0};
				end
				s_next.cnt = s_reg.cnt - 1'b1;
				if (s_reg.cnt == CNT_W'(1))
				begin
					s_next.state = SRS_DIV_IDLE;
					s_next.done = 1'b1;
					s_next.result = s_next.quo;
				end
			end
			default:
				s_next.state = SRS_DIV_IDLE;
		endcase
	end
	always_ff @(posedge clk)
	begin
		if (reset)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end
	assign done = s_reg.done;
	assign quotient = s_reg.result;
endmodule

// >>> hdl/srs_shaper.sv
// solenoid reference shaper with apb configuration port
`timescale 1ns/1ps
module srs_shaper
#(
	parameter int TICK_CYC = srs_pkg::RAMP_TICK_CYC
)
(
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        reset,
	// apb slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// references and feedback
	input  wire logic signed [srs_pkg::DATA_W-1:0] analog_ref,
	input  wire logic signed [srs_pkg::DATA_W-1:0] fieldbus_ref,
	input  wire logic [srs_pkg::DATA_W-1:0]  pressure_feedback_input,
	input  wire logic                        enable_in,
	// current loop side
	output logic signed [srs_pkg::DATA_W-1:0] current_setpoint,
	output logic [srs_pkg::DATA_W-1:0]       dither_step,
	output logic                             power_limited
);
	import srs_pkg::*;
	localparam int TW = $clog2(TICK_CYC + 1);
	initial
	begin
		if (TICK_CYC < 1)
			$error("srs_shaper: ramp tick must be at least one cycle");
	end
	typedef logic signed [31:0] s32_t;
	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [15:0]       scale_pos;
		logic [15:0]       scale_neg;
		logic [15:0]       bias_pos;
		logic [15:0]       bias_neg;
		logic [15:0]       threshold;
		logic [15:0]       offset;
		logic [3:0][15:0]  rate;
		logic [15:0]       lin_knee;
		logic [15:0]       lin_gain;
		logic [15:0]       dith_base;
		logic [15:0]       dith_slope;
		logic [15:0]       dith_amp;
		logic [31:0]       pcap;
		logic [15:0]       ramp_val;
		logic [TW-1:0]     tick_cnt;
		logic [23:0]       phase;
		logic [15:0]       setpoint;
		logic [15:0]       dstep;
		logic              limited;
		logic [31:0]       rdata;
		logic              ready;
		logic              slverr;
	} srs_state_t;
	srs_state_t s_reg;
	srs_state_t s_next;

	function automatic logic [15:0] mag(input logic [15:0] v);
		mag = v[15] ? 16'(-v) : v;
	endfunction
	function automatic logic [15:0] clamp(input s32_t v, input s32_t lo,
		input s32_t hi);
		if (v > hi)
			clamp = hi[15:0];
		else if (v < lo)
			clamp = lo[15:0];
		else
			clamp = v[15:0];
	endfunction
	function automatic s32_t sx(input logic [15:0] v);
		sx = 32'(signed'(v));
	endfunction
	function automatic s32_t zx(input logic [15:0] v);
		zx = s32_t'({16'h0000, v});
	endfunction

	localparam s32_t FS_POS = 32'sh00007FFF;
	localparam s32_t FS_NEG = -32'sh00007FFF;
	logic        access;
	logic        mapped;
	logic [31:0] rd_mux;
	logic [15:0] src;
	logic [15:0] flow_mag;
	logic [31:0] power_req;
	logic        limit_hit;
	logic [15:0] lim_mag;
	logic [15:0] target;
	logic [15:0] step;
	logic [1:0]  rsel;
	logic        tick;
	logic [15:0] lin;
	logic [15:0] lin_mag;
	logic [15:0] biased;
	logic signed [47:0] scaled;
	logic [15:0] cur;
	logic        div_done;
	logic [31:0] quotient;
	logic [31:0] dprod;

	srs_divider #(.NUM_W(32), .DEN_W(16)) u_div (
		.clk         (clk),
		.reset       (reset),
		.start       (1'b1),
		.numerator   (s_reg.pcap),
		.denominator (pressure_feedback_input),
		.done        (div_done),
		.quotient    (quotient)
	);

	always_comb
	begin
		s_next = s_reg;
		// apb: one wait state, write and read data at the pready edge
		access = psel && penable && s_reg.ready;
		mapped = 1'b1;
		rd_mux = 32'h00000000;
		case (paddr)
			OFS_CTRL:      rd_mux = {27'h0000000, s_reg.ctrl};
			OFS_SCALE_POS: rd_mux = zx(s_reg.scale_pos);
			OFS_SCALE_NEG: rd_mux = zx(s_reg.scale_neg);
			OFS_BIAS_POS:  rd_mux = zx(s_reg.bias_pos);
			OFS_BIAS_NEG:  rd_mux = zx(s_reg.bias_neg);
			OFS_THRESHOLD: rd_mux = zx(s_reg.threshold);
			OFS_OFFSET:    rd_mux = zx(s_reg.offset);
			OFS_RATE01:    rd_mux = {s_reg.rate[1], s_reg.rate[0]};
			OFS_RATE23:    rd_mux = {s_reg.rate[3], s_reg.rate[2]};
			OFS_LIN:       rd_mux = {s_reg.lin_gain, s_reg.lin_knee};
			OFS_DITHER:    rd_mux = {s_reg.dith_slope, s_reg.dith_base};
			OFS_DITH_AMP:  rd_mux = zx(s_reg.dith_amp);
			OFS_PCAP:      rd_mux = s_reg.pcap;
			OFS_STATUS:    rd_mux = {14'h0000, enable_in, s_reg.limited,
				s_reg.setpoint};
			default:       mapped = 1'b0;
		endcase
		s_next.ready = psel && penable && !s_reg.ready;
		s_next.rdata = (s_next.ready && !pwrite) ? rd_mux : 32'h00000000;
		s_next.slverr = s_next.ready && !mapped;
		// no lockout by the reference source: writes land at any time
		if (access && pwrite)
		begin
			case (paddr)
				OFS_CTRL:      s_next.ctrl = pwdata[CTRL_W-1:0];
				OFS_SCALE_POS: s_next.scale_pos = pwdata[15:0];
				OFS_SCALE_NEG: s_next.scale_neg = pwdata[15:0];
				OFS_BIAS_POS:  s_next.bias_pos = pwdata[15:0];
				OFS_BIAS_NEG:  s_next.bias_neg = pwdata[15:0];
				OFS_THRESHOLD: s_next.threshold = pwdata[15:0];
				OFS_OFFSET:    s_next.offset = pwdata[15:0];
				OFS_RATE01:    s_next.rate[1:0] = pwdata;
				OFS_RATE23:    s_next.rate[3:2] = pwdata;
				OFS_LIN:       {s_next.lin_gain, s_next.lin_knee} = pwdata;
				OFS_DITHER:    {s_next.dith_slope, s_next.dith_base} = pwdata;
				OFS_DITH_AMP:  s_next.dith_amp = pwdata[15:0];
				OFS_PCAP:      s_next.pcap = pwdata;
				default:       s_next.ctrl = s_reg.ctrl;
			endcase
		end
		// reference source
		src = s_reg.ctrl[CTRL_SRC_BIT] ? fieldbus_ref : analog_ref;
		// power limiter on the flow magnitude
		flow_mag = mag(src);
		power_req = 32'(pressure_feedback_input) * 32'(flow_mag);
		limit_hit = s_reg.ctrl[CTRL_PLIM_BIT] && power_req >= s_reg.pcap
			&& pressure_feedback_input != 16'h0000;
		lim_mag = flow_mag;
		if (limit_hit && quotient < 32'(flow_mag))
			lim_mag = quotient[15:0];
		target = src[15] ? 16'(-lim_mag) : lim_mag;
		s_next.limited = limit_hit;
		// ramp generator, stepping once per tick
		tick = s_reg.tick_cnt == '0;
		s_next.tick_cnt = tick ? TW'(TICK_CYC - 1) : s_reg.tick_cnt - 1'b1;
		case (srs_ramp_mode_t'(s_reg.ctrl[CTRL_MODE_LSB +: 2]))
			SRS_RAMP_SINGLE: rsel = 2'b00;
			SRS_RAMP_UPDOWN: rsel = {1'b0, sx(target) < sx(s_reg.ramp_val)};
			SRS_RAMP_QUAD:   rsel = {s_reg.ramp_val[15],
				sx(target) < sx(s_reg.ramp_val)};
			default:         rsel = 2'b00;
		endcase
		step = s_reg.rate[rsel];
		if (!s_reg.ctrl[CTRL_RAMP_BIT])
			s_next.ramp_val = target;
		else if (tick)
		begin
			if (sx(target) > sx(s_reg.ramp_val) + zx(step))
				s_next.ramp_val = 16'(sx(s_reg.ramp_val) + zx(step));
			else if (sx(target) < sx(s_reg.ramp_val) - zx(step))
				s_next.ramp_val = 16'(sx(s_reg.ramp_val) - zx(step));
			else
				s_next.ramp_val = target;
		end
		// linearization: gain applies to the part above the knee
		lin_mag = mag(s_reg.ramp_val);
		if (lin_mag > s_reg.lin_knee)
			lin_mag = clamp(zx(s_reg.lin_knee) + 32'((zx(lin_mag)
				- zx(s_reg.lin_knee)) * zx(s_reg.lin_gain) >>> LIN_FRAC),
				32'sh0, FS_POS);
		lin = s_reg.ramp_val[15] ? 16'(-lin_mag) : lin_mag;
		// bias above the threshold, chosen by polarity
		biased = lin;
		if (mag(lin) > s_reg.threshold)
			biased = lin[15] ? clamp(sx(lin) - zx(s_reg.bias_neg), FS_NEG,
				FS_POS) : clamp(sx(lin) + zx(s_reg.bias_pos), FS_NEG,
				FS_POS);
		// scale: full-scale reference gives the programmed current
		scaled = 48'(sx(biased)) * 48'(zx(biased[15] ? s_reg.scale_neg
			: s_reg.scale_pos));
		cur = clamp(32'(scaled >>> SCALE_FRAC) + sx(s_reg.offset),
			-zx(s_reg.scale_neg), zx(s_reg.scale_pos));
		// dither rate rises linearly with demanded current
		dprod = 32'(zx(s_reg.dith_slope) * zx(mag(cur)) >>> SCALE_FRAC);
		s_next.dstep = clamp(zx(s_reg.dith_base) + s32_t'(dprod), 32'sh0,
			32'sh0000FFFF);
		s_next.phase = s_reg.phase + 24'(s_reg.dstep);
		s_next.setpoint = 16'h0000;
		if (enable_in)
			s_next.setpoint = clamp(sx(cur) + (s_reg.phase[23]
				? zx(s_reg.dith_amp) : -zx(s_reg.dith_amp)),
				-zx(s_reg.scale_neg), zx(s_reg.scale_pos));
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			s_reg <= '0;
			s_reg.ctrl <= RST_CTRL;
			s_reg.scale_pos <= RST_SCALE;
			s_reg.scale_neg <= RST_SCALE;
			s_reg.bias_pos <= RST_ZERO16;
			s_reg.bias_neg <= RST_ZERO16;
			s_reg.threshold <= RST_ZERO16;
			s_reg.offset <= RST_ZERO16;
			s_reg.rate <= {4{RST_RATE}};
			s_reg.lin_knee <= RST_LIN_KNEE;
			s_reg.lin_gain <= RST_LIN_GAIN;
			s_reg.dith_base <= RST_DITH_BASE;
			s_reg.dith_slope <= RST_DITH_SLP;
			s_reg.dith_amp <= RST_ZERO16;
			s_reg.pcap <= RST_PCAP;
		end
		else
			s_reg <= s_next;
	end
	assign prdata = s_reg.rdata;
	assign pready = s_reg.ready;
	assign pslverr = s_reg.slverr;
	assign current_setpoint = s_reg.setpoint;
	assign dither_step = s_reg.dstep;
	assign power_limited = s_reg.limited;

	AST_ENABLE_ZERO: assert property (@(posedge clk)
		disable iff (reset) !enable_in |=> current_setpoint == 16'h0000)
		else $error("setpoint not zero while disabled");
	AST_RAMP_BYPASS: assert property (@(posedge clk)
		disable iff (reset)
		!s_reg.ctrl[CTRL_RAMP_BIT] |=> s_reg.ramp_val == $past(target))
		else $error("disabled ramp did not pass reference");
	AST_RAMP_STEP: assert property (@(posedge clk)
		disable iff (reset) s_reg.ctrl[CTRL_RAMP_BIT] && !tick
		|=> s_reg.ramp_val == $past(s_reg.ramp_val))
		else $error("ramp moved between ticks");
	AST_SAT_RANGE: assert property (@(posedge clk)
		disable iff (reset) sx(current_setpoint) <= zx(s_reg.scale_pos)
		|| $changed(s_reg.scale_pos))
		else $error("setpoint above positive scale");
	AST_SAT_NEG: assert property (@(posedge clk)
		disable iff (reset) sx(current_setpoint) >= -zx(s_reg.scale_neg)
		|| $changed(s_reg.scale_neg))
		else $error("setpoint below negative scale");
	AST_PRESS_ZERO: assert property (@(posedge clk)
		disable iff (reset)
		pressure_feedback_input == 16'h0000 |-> target == src)
		else $error("zero pressure altered the flow");
	AST_LIMIT_MIN: assert property (@(posedge clk)
		disable iff (reset) limit_hit |-> lim_mag <= flow_mag
		&& (lim_mag == flow_mag || 32'(lim_mag) == quotient))
		else $error("limited flow is not the minimum");
	AST_NO_BIAS: assert property (@(posedge clk)
		disable iff (reset) mag(lin) <= s_reg.threshold |-> biased == lin)
		else $error("bias added at or below threshold");
	AST_SCALE_WRITE: assert property (@(posedge clk)
		disable iff (reset) access && pwrite && paddr == OFS_SCALE_POS
		|=> s_reg.scale_pos == $past(pwdata[15:0]))
		else $error("scale write lost");
	AST_APB_WAIT: assert property (@(posedge clk) disable iff (reset)
		psel && !penable ##1 psel && penable |-> !pready ##1 pready)
		else $error("apb answer not after one wait state");
	COV_LIMIT: cover property (@(posedge clk) disable iff (reset)
		limit_hit ##1 power_limited);
	COV_RAMP: cover property (@(posedge clk) disable iff (reset)
		s_reg.ctrl[CTRL_RAMP_BIT] && tick && target != s_reg.ramp_val);
	COV_SLVERR: cover property (@(posedge clk) disable iff (reset)
		pslverr);
	COV_DIV: cover property (@(posedge clk) disable iff (reset)
		div_done && limit_hit);
endmodule

// >>> tb/srs_coil_model.sv
// behavioural solenoid current loop that follows the shaper setpoint
`timescale 1ns/1ps
module srs_coil_model
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               reset,
	// command from the shaper
	input  wire logic signed [15:0] current_setpoint,
	input  wire logic [15:0]        dither_step,
	// measured coil current
	output logic signed [15:0]      coil_current
);
	// first-order lag: coil inductance never lets the current jump
	always_ff @(posedge clk)
		if (reset)
			coil_current <= 16'h0000;
		else
			coil_current <= coil_current
				+ ((current_setpoint - coil_current) >>> 2);
endmodule

// >>> tb/solenoid_reference_shaper_bench.sv
// self-checking bench of the solenoid reference shaper
`timescale 1ns/1ps
module solenoid_reference_shaper_bench;
	import srs_pkg::*;
	// short ramp tick keeps the ramp scenarios brief
	localparam int TICK = 4;
	logic               clk, reset, psel, penable, pwrite, pready, pslverr;
	logic        [7:0]  paddr;
	logic        [31:0] pwdata, prdata, rd;
	logic signed [15:0] analog_ref, fieldbus_ref, current_setpoint, coil;
	logic        [15:0] pressure_feedback_input, dither_step;
	logic               enable_in, power_limited, err;
	int                 error_cnt, total_checks, cyc;
	logic        [7:0]  ra [6] = '{OFS_CTRL, OFS_SCALE_POS, OFS_RATE01,
		OFS_LIN, OFS_DITHER, OFS_PCAP};
	logic        [31:0] rv [6] = '{32'h00000000, 32'h00007FFF,
		32'h00400040, 32'h01007FFF, 32'h01000100, 32'hFFFFFFFF};
	logic        [15:0] bref [4] = '{16'h0064, 16'h0066, 16'hFF9C, 16'hFF9A};
	logic        [15:0] bexp [4] = '{16'h0032, 16'h0097, 16'hFFCE, 16'hFF37};

	srs_shaper #(.TICK_CYC(TICK)) u_srs_shaper
	(
		.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .analog_ref(analog_ref),
		.fieldbus_ref(fieldbus_ref),
		.pressure_feedback_input(pressure_feedback_input),
		.enable_in(enable_in), .current_setpoint(current_setpoint),
		.dither_step(dither_step), .power_limited(power_limited)
	);
	srs_coil_model u_srs_coil_model
	(
		.clk(clk), .reset(reset), .current_setpoint(current_setpoint),
		.dither_step(dither_step), .coil_current(coil)
	);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// the bench timeout is the only bound on the pready wait
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rng(input string nm, input logic signed [15:0] lo,
		input logic signed [15:0] hi);
		total_checks++;
		if (^current_setpoint === 1'bx || current_setpoint < lo
			|| current_setpoint > hi)
		begin
			error_cnt++;
			$display("Error %s expected %h..%h seen %h", nm, lo, hi,
				current_setpoint);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic spc(input logic [15:0] e);
		chk("setpoint", {16'h0000, e}, {16'h0000, current_setpoint});
	endtask

	task automatic drive(input logic [15:0] a, input int n);
		analog_ref <= a;
		repeat (n) @(posedge clk);
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			report_and_stop();
		end
	end

	initial
	begin
		reset <= 1'b1;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0;
		analog_ref <= 16'h0000;
		fieldbus_ref <= 16'h0000;
		pressure_feedback_input <= 16'h0000;
		enable_in <= 1'b1;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b0, ra[i], 32'h0);
			chk("reset value", rv[i], rd);
		end
		wr(OFS_STATUS, 32'hFFFFFFFF);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("status", 32'h00020000, rd);
		apb(1'b0, 8'h38, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		drive(16'h03E8, 4);
		spc(16'h03E7);
		wr(OFS_SCALE_POS, 32'h4000);
		wr(OFS_SCALE_NEG, 32'h2000);
		drive(16'h7FFF, 4);
		spc(16'h3FFF);
		drive(16'h8004, 4);
		spc(16'hE001);
		wr(OFS_OFFSET, 32'h7000);
		drive(16'h7FFF, 4);
		spc(16'h4000);
		wr(OFS_OFFSET, 32'h9000);
		drive(16'h8004, 4);
		spc(16'hE000);
		wr(OFS_OFFSET, 32'h0);
		wr(OFS_SCALE_NEG, 32'h4000);
		wr(OFS_THRESHOLD, 32'h64);
		wr(OFS_BIAS_POS, 32'hC8);
		wr(OFS_BIAS_NEG, 32'h12C);
		for (int i = 0; i < 4; i++)
		begin
			drive(bref[i], 4);
			spc(bexp[i]);
		end
		wr(OFS_THRESHOLD, 32'h0);
		fieldbus_ref <= 16'h03E8;
		wr(OFS_CTRL, 32'h1);
		drive(16'h0010, 4);
		spc(16'h0258);
		wr(OFS_BIAS_POS, 32'h64);
		repeat (4) @(posedge clk);
		spc(16'h0226);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_BIAS_POS, 32'h0);
		wr(OFS_BIAS_NEG, 32'h0);
		wr(OFS_OFFSET, 32'h64);
		drive(16'h0000, 4);
		spc(16'h0064);
		wr(OFS_OFFSET, 32'h2000);
		repeat (4) @(posedge clk);
		chk("dither step", 32'h140, {16'h0, dither_step});
		wr(OFS_OFFSET, 32'h4000);
		repeat (4) @(posedge clk);
		chk("dither step", 32'h180, {16'h0, dither_step});
		wr(OFS_OFFSET, 32'h2000);
		wr(OFS_DITH_AMP, 32'h10);
		repeat (4) @(posedge clk);
		rng("dithered", 16'h1FF0, 16'h2010);
		spc(16'h1FF0);
		wr(OFS_DITH_AMP, 32'h0);
		wr(OFS_OFFSET, 32'h0);
		drive(16'h7FFF, 4);
		enable_in <= 1'b0;
		repeat (3) @(posedge clk);
		spc(16'h0000);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("status", 32'h0, rd);
		repeat (60) @(posedge clk);
		chk("coil", 32'h0, {16'h0, coil});
		enable_in <= 1'b1;
		wr(OFS_SCALE_POS, 32'h7FFF);
		wr(OFS_LIN, 32'h020003E8);
		drive(16'h07D0, 4);
		rng("linearized", 16'h0BAE, 16'h0BB8);
		wr(OFS_LIN, 32'h01007FFF);
		wr(OFS_PCAP, 32'hC350);
		pressure_feedback_input <= 16'h0064;
		wr(OFS_CTRL, 32'h10);
		drive(16'h03E8, 100);
		chk("limited", 32'h1, {31'h0, power_limited});
		rng("limited setpoint", 16'h01EF, 16'h01F4);
		pressure_feedback_input <= 16'h0000;
		repeat (100) @(posedge clk);
		chk("limited", 32'h0, {31'h0, power_limited});
		rng("passed setpoint", 16'h03E3, 16'h03E8);
		wr(OFS_SCALE_POS, 32'h4000);
		wr(OFS_RATE01, 32'h7FFF0040);
		wr(OFS_RATE23, 32'h7FFF7FFF);
		for (int m = 0; m < 3; m++)
		begin
			wr(OFS_CTRL, 32'h0);
			drive(16'h0000, 4);
			wr(OFS_CTRL, {27'h0, 1'b0, m[1:0], 2'b10});
			drive(16'h4E20, 40);
			rng("ramp rise", 16'h0001, 16'h270F);
			repeat (1500) @(posedge clk);
			spc(16'h2710);
			drive(16'h0000, 40);
			if (m == 0)
				rng("ramp fall", 16'h0001, 16'h270F);
			else
				spc(16'h0000);
			if (m == 2)
			begin
				drive(16'hB1E0, 8);
				spc(16'hD8F0);
				drive(16'h0000, 8);
				spc(16'h0000);
			end
		end
		report_and_stop();
	end
endmodule
